// >>> pkg/flash_host_pkg.sv
// constants and types shared by the flash command controller
`default_nettype none
package flash_host_pkg;
  // ---------------------------------------------------------------
  // clock and pin timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_WP_NS = 80;     // write strobe low, least
  localparam int T_ACC_NS = 200;   // read access, least wait
  localparam int T_RST_NS = 5000;  // wait after return to array during erase
  localparam int T_SUSP_NS = 15000;  // latest stop of toggling after suspend
  localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_WAIT_CYC = (T_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SUSP_WAIT_CYC = (T_SUSP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_W = 8;
  // ---------------------------------------------------------------
  // command codes, addresses and status bit positions
  // ---------------------------------------------------------------
  localparam logic [18:0] CMD_ADDR = 19'h05555;
  localparam logic [7:0] CODE_SETUP = 8'h80;
  localparam logic [7:0] CODE_CHIP = 8'h10;
  localparam logic [7:0] CODE_BLOCK = 8'h30;
  localparam logic [7:0] CODE_PROG = 8'ha0;
  localparam logic [7:0] CODE_SUSP = 8'hb0;
  localparam logic [7:0] CODE_RESUME = 8'h30;
  localparam logic [7:0] CODE_RESET = 8'hf0;
  localparam int POLL_BIT = 7;     // data_poll_flag
  localparam int TOGGLE_BIT = 6;   // toggle_flag
  localparam int FAIL_BIT = 5;     // fail_flag
  localparam int WINDOW_BIT = 3;   // erase_window_flag
  localparam logic [2:0] STEP_RESET = 3'h0;
  // ---------------------------------------------------------------
  // user operations
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_PROGRAM = 4'h1, OP_CHIP_ERASE = 4'h2, OP_BLOCK_ERASE = 4'h3,
    OP_ADD_BLOCK = 4'h4, OP_SUSPEND = 4'h5, OP_RESUME = 4'h6, OP_RESET = 4'h7, OP_POLL = 4'h8
  } op_t;
endpackage
`default_nettype wire

// >>> pkg/flash_cycle_if.sv
// carrier between the sequencer and the single bus cycle engine
`default_nettype none
interface flash_cycle_if;
  logic start;
  logic wr;
  logic [18:0] addr;
  logic [7:0] wdata;
  logic done;
  logic busy;
  logic [7:0] rdata;
  modport ctrl (output start, output wr, output addr, output wdata, input done, input busy, input rdata);
  modport unit (input start, input wr, input addr, input wdata, output done, output busy, output rdata);
endinterface
`default_nettype wire

// >>> rtl/flash_cycle_unit.sv
// one read or one write cycle on the flash pins
`default_nettype none
module flash_cycle_unit
  import flash_host_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // sequencer side
  flash_cycle_if.unit cyc,
  // flash pins
  output logic [18:0] fl_addr,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n,
  output logic [7:0] fl_dq_out,
  output logic fl_dq_oe,
  input wire logic [7:0] fl_dq_in
);
  // ---------------------------------------------------------------
  // cycle phases
  // ---------------------------------------------------------------
  logic busy_reg, busy_next, wr_reg, wr_next, done_reg, done_next;
  logic ce_n_reg, ce_n_next, we_n_reg, we_n_next, oe_n_reg, oe_n_next, dq_oe_reg, dq_oe_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [18:0] addr_reg, addr_next;
  logic [7:0] wdata_reg, wdata_next, rdata_reg, rdata_next;

  // write: chip enable low, write strobe low for WP_CYC, strobe high (data latched), release
  always_comb begin
    busy_next = busy_reg;
    wr_next = wr_reg;
    done_next = 1'b0;
    ce_n_next = ce_n_reg;
    we_n_next = we_n_reg;
    oe_n_next = oe_n_reg;
    dq_oe_next = dq_oe_reg;
    cnt_next = cnt_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    if (!busy_reg) begin
      if (cyc.start) begin
        busy_next = 1'b1;
        wr_next = cyc.wr;
        addr_next = cyc.addr;
        wdata_next = cyc.wdata;
        ce_n_next = 1'b0;
        oe_n_next = cyc.wr;
        dq_oe_next = cyc.wr;
        cnt_next = 4'h0;
      end
    end else begin
      cnt_next = cnt_reg + 4'h1;
      if (wr_reg) begin
        if (cnt_reg == 4'h0) begin
          we_n_next = 1'b0;
        end else if (cnt_reg == 4'(WP_CYC)) begin
          we_n_next = 1'b1;
        end else if (cnt_reg > 4'(WP_CYC)) begin
          // strobe rose a cycle ago with data still driven: hold time met
          ce_n_next = 1'b1;
          dq_oe_next = 1'b0;
          busy_next = 1'b0;
          done_next = 1'b1;
        end
      // sample only after the whole access time has passed since enable went low
      end else if (cnt_reg == 4'(RD_CYC)) begin
        rdata_next = fl_dq_in;
        ce_n_next = 1'b1;
        oe_n_next = 1'b1;
        busy_next = 1'b0;
        done_next = 1'b1;
      end
    end
  end

  // registers only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_reg <= 1'b0;
      wr_reg <= 1'b0;
      done_reg <= 1'b0;
      ce_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      dq_oe_reg <= 1'b0;
      cnt_reg <= 4'h0;
      addr_reg <= 19'h00000;
      wdata_reg <= 8'h00;
      rdata_reg <= 8'h00;
    end else begin
      busy_reg <= busy_next;
      wr_reg <= wr_next;
      done_reg <= done_next;
      ce_n_reg <= ce_n_next;
      we_n_reg <= we_n_next;
      oe_n_reg <= oe_n_next;
      dq_oe_reg <= dq_oe_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
    end
  end

  assign cyc.done = done_reg;
  assign cyc.busy = busy_reg;
  assign cyc.rdata = rdata_reg;
  assign fl_addr = addr_reg;
  assign fl_ce_n = ce_n_reg;
  assign fl_we_n = we_n_reg;
  assign fl_oe_n = oe_n_reg;
  assign fl_dq_out = wdata_reg;
  assign fl_dq_oe = dq_oe_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_strobe_inside_ce: assert property (@(posedge clk) disable iff (!arst_n)
    !we_n_reg |-> !ce_n_reg && dq_oe_reg && oe_n_reg) else $error("write strobe outside chip enable");
  a_read_no_drive: assert property (@(posedge clk) disable iff (!arst_n)
    !oe_n_reg |-> !dq_oe_reg && we_n_reg) else $error("bus driven during read");
  a_write_length: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(we_n_reg) |-> !we_n_reg ##1 $rose(we_n_reg) ##0 !ce_n_reg ##1 ce_n_reg)
    else $error("write cycle shape wrong");
endmodule
`default_nettype wire

// >>> rtl/flash_erase_host.sv
// controller that drives the parallel flash through its command sequences
`default_nettype none
module flash_erase_host
  import flash_host_pkg::*;
#(
  parameter logic [18:0] UNLOCK1_ADDR = 19'h00001,  // arbitrary default
  parameter logic [7:0] UNLOCK1_DATA = 8'h01,       // arbitrary default
  parameter logic [18:0] UNLOCK2_ADDR = 19'h00002,  // arbitrary default
  parameter logic [7:0] UNLOCK2_DATA = 8'h02        // arbitrary default
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  // user requests
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic [3:0] REQ_OP,
  input wire logic [18:0] REQ_ADDR,
  input wire logic [7:0] REQ_DATA,
  // user answers
  output logic RSP_VALID,
  output logic [7:0] RSP_DATA,
  output logic RSP_FAIL,
  output logic RSP_REFUSED,
  output logic ERASE_PENDING,
  output logic ERASE_SUSPENDED,
  // flash pins
  output logic [18:0] FL_ADDR,
  output logic FL_CE_N,
  output logic FL_WE_N,
  output logic FL_OE_N,
  output logic [7:0] FL_DQ_OUT,
  output logic FL_DQ_OE,
  input wire logic [7:0] FL_DQ_IN
);
  // ---------------------------------------------------------------
  // state and registers
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_WRITE = 3'b001, S_WAIT = 3'b011, S_POLL_A = 3'b010,
    S_POLL_B = 3'b110, S_READ = 3'b100
  } state_t;

  state_t state_reg, state_next;
  op_t op_reg, op_next;
  logic [18:0] addr_reg, addr_next;
  logic [7:0] data_reg, data_next, first_reg, first_next;
  logic [2:0] step_reg, step_next;
  logic [WAIT_W-1:0] wait_reg, wait_next;
  logic issued_reg, issued_next, fail_seen_reg, fail_seen_next;
  logic erase_reg, erase_next, susp_reg, susp_next;
  logic rsp_valid_reg, rsp_valid_next, rsp_fail_reg, rsp_fail_next, rsp_ref_reg, rsp_ref_next;
  logic [7:0] rsp_data_reg, rsp_data_next;
  logic [2:0] last_step;
  logic refuse;
  logic [26:0] word;
  op_t req_op;

  flash_cycle_if cyc ();

  // ---------------------------------------------------------------
  // write list of each sequence
  // ---------------------------------------------------------------
  // sequence write lists
  // one word = {address, data}; single-write commands need no unlock cycles
  function automatic logic [26:0] seq_word(op_t op, logic [2:0] s, logic [18:0] a, logic [7:0] d);
    logic [26:0] w;
    w = {a, CODE_RESET};
    case (op)
      OP_ADD_BLOCK: w = {a, CODE_BLOCK};
      OP_SUSPEND: w = {a, CODE_SUSP};
      OP_RESUME: w = {a, CODE_RESUME};
      OP_RESET: w = {a, CODE_RESET};
      default: begin
        case (s)
          3'h0: w = {UNLOCK1_ADDR, UNLOCK1_DATA};
          3'h1: w = {UNLOCK2_ADDR, UNLOCK2_DATA};
          3'h2: w = {CMD_ADDR, (op == OP_PROGRAM) ? CODE_PROG : CODE_SETUP};
          3'h3: w = (op == OP_PROGRAM) ? {a, d} : {UNLOCK1_ADDR, UNLOCK1_DATA};
          3'h4: w = {UNLOCK2_ADDR, UNLOCK2_DATA};
          default: w = (op == OP_CHIP_ERASE) ? {CMD_ADDR, CODE_CHIP} : {a, CODE_BLOCK};
        endcase
      end
    endcase
    return w;
  endfunction

  assign word = seq_word(op_reg, step_reg, addr_reg, data_reg);
  assign last_step = (op_reg == OP_PROGRAM) ? 3'h3 :
                     (op_reg == OP_CHIP_ERASE || op_reg == OP_BLOCK_ERASE) ? 3'h5 : 3'h0;
  assign req_op = op_t'(REQ_OP);

  // suspend only while erasing
  // commands the flash would ignore or that would abandon work are refused here
  assign refuse = (req_op == OP_SUSPEND && (!erase_reg || susp_reg)) ||
                  (req_op == OP_ADD_BLOCK && (!erase_reg || susp_reg)) ||
                  (req_op == OP_RESUME && !susp_reg) ||
                  (req_op == OP_POLL && susp_reg) ||
                  (req_op > OP_POLL) ||
                  ((req_op == OP_PROGRAM || req_op == OP_CHIP_ERASE || req_op == OP_BLOCK_ERASE) &&
                   (erase_reg || susp_reg));

  // cycle requests: one outstanding at a time
  assign cyc.start = (state_reg != S_IDLE) && (state_reg != S_WAIT) && !issued_reg;
  assign cyc.wr = (state_reg == S_WRITE);
  assign cyc.addr = (state_reg == S_WRITE) ? word[26:8] : addr_reg;
  assign cyc.wdata = word[7:0];

  // ---------------------------------------------------------------
  // sequencer next state
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    first_next = first_reg;
    step_next = step_reg;
    wait_next = wait_reg;
    issued_next = issued_reg;
    fail_seen_next = fail_seen_reg;
    erase_next = erase_reg;
    susp_next = susp_reg;
    rsp_valid_next = 1'b0;
    rsp_fail_next = rsp_fail_reg;
    rsp_ref_next = rsp_ref_reg;
    rsp_data_next = rsp_data_reg;
    if (cyc.start) begin
      issued_next = 1'b1;
    end
    if (cyc.done) begin
      issued_next = 1'b0;
    end
    case (state_reg)
      S_IDLE: begin
        if (REQ_VALID) begin
          op_next = req_op;
          addr_next = REQ_ADDR;
          data_next = REQ_DATA;
          step_next = STEP_RESET;
          fail_seen_next = 1'b0;
          if (refuse) begin
            rsp_valid_next = 1'b1;
            rsp_ref_next = 1'b1;
            rsp_fail_next = 1'b0;
          end else if (req_op == OP_READ) begin
            state_next = S_READ;
          end else if (req_op == OP_POLL) begin
            state_next = S_POLL_A;
          end else begin
            state_next = S_WRITE;
          end
        end
      end
      S_WRITE: begin
        if (cyc.done) begin
          step_next = step_reg + 3'h1;
          if (step_reg == last_step) begin
            step_next = STEP_RESET;
            case (op_reg)
              OP_PROGRAM, OP_CHIP_ERASE: state_next = S_POLL_A;
              OP_SUSPEND: begin
                susp_next = 1'b1;
                wait_next = WAIT_W'(SUSP_WAIT_CYC);
                state_next = S_WAIT;
              end
              OP_RESET: begin
                erase_next = 1'b0;
                susp_next = 1'b0;
                wait_next = WAIT_W'(RST_WAIT_CYC);
                state_next = S_WAIT;
              end
              OP_RESUME: begin
                susp_next = 1'b0;
                state_next = S_IDLE;
                rsp_valid_next = 1'b1;
                rsp_ref_next = 1'b0;
                rsp_fail_next = 1'b0;
              end
              // window left open for more blocks
              default: begin
                erase_next = 1'b1;
                state_next = S_IDLE;
                rsp_valid_next = 1'b1;
                rsp_ref_next = 1'b0;
                rsp_fail_next = 1'b0;
              end
            endcase
          end
        end
      end
      S_WAIT: begin
        wait_next = wait_reg - WAIT_W'(1);
        if (wait_reg == WAIT_W'(1)) begin
          state_next = S_IDLE;
          rsp_valid_next = 1'b1;
          rsp_ref_next = 1'b0;
          rsp_fail_next = fail_seen_reg;
        end
      end
      S_READ: begin
        if (cyc.done) begin
          state_next = S_IDLE;
          rsp_valid_next = 1'b1;
          rsp_ref_next = 1'b0;
          rsp_fail_next = 1'b0;
          rsp_data_next = cyc.rdata;
        end
      end
      S_POLL_A: begin
        if (cyc.done) begin
          first_next = cyc.rdata;
          state_next = S_POLL_B;
        end
      end
      S_POLL_B: begin
        if (cyc.done) begin
          if (first_reg[TOGGLE_BIT] == cyc.rdata[TOGGLE_BIT]) begin
            state_next = S_IDLE;
            erase_next = 1'b0;
            rsp_valid_next = 1'b1;
            rsp_ref_next = 1'b0;
            rsp_fail_next = fail_seen_reg;
            rsp_data_next = cyc.rdata;
          end else if (cyc.rdata[FAIL_BIT]) begin
            if (fail_seen_reg) begin
              op_next = OP_RESET;
              step_next = STEP_RESET;
              rsp_data_next = cyc.rdata;
              state_next = S_WRITE;
            end else begin
              // fail flag may rise just before toggling stops: read once more
              fail_seen_next = 1'b1;
              state_next = S_POLL_A;
            end
          end else begin
            state_next = S_POLL_A;
          end
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  // registers only
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= S_IDLE;
      op_reg <= OP_READ;
      addr_reg <= 19'h00000;
      data_reg <= 8'h00;
      first_reg <= 8'h00;
      step_reg <= 3'h0;
      wait_reg <= '0;
      issued_reg <= 1'b0;
      fail_seen_reg <= 1'b0;
      erase_reg <= 1'b0;
      susp_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_fail_reg <= 1'b0;
      rsp_ref_reg <= 1'b0;
      rsp_data_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      first_reg <= first_next;
      step_reg <= step_next;
      wait_reg <= wait_next;
      issued_reg <= issued_next;
      fail_seen_reg <= fail_seen_next;
      erase_reg <= erase_next;
      susp_reg <= susp_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_fail_reg <= rsp_fail_next;
      rsp_ref_reg <= rsp_ref_next;
      rsp_data_reg <= rsp_data_next;
    end
  end

  assign REQ_READY = (state_reg == S_IDLE);
  assign RSP_VALID = rsp_valid_reg;
  assign RSP_DATA = rsp_data_reg;
  assign RSP_FAIL = rsp_fail_reg;
  assign RSP_REFUSED = rsp_ref_reg;
  assign ERASE_PENDING = erase_reg;
  assign ERASE_SUSPENDED = susp_reg;

  flash_cycle_unit u_cycle (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .cyc(cyc.unit),
    .fl_addr(FL_ADDR),
    .fl_ce_n(FL_CE_N),
    .fl_we_n(FL_WE_N),
    .fl_oe_n(FL_OE_N),
    .fl_dq_out(FL_DQ_OUT),
    .fl_dq_oe(FL_DQ_OE),
    .fl_dq_in(FL_DQ_IN)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_unlock_first: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    cyc.start && cyc.wr && step_reg == 3'h0 && last_step != 3'h0 |->
    cyc.addr == UNLOCK1_ADDR && cyc.wdata == UNLOCK1_DATA) else $error("unlock cycle wrong");
  a_setup_third: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    cyc.start && cyc.wr && step_reg == 3'h2 && op_reg == OP_CHIP_ERASE |->
    cyc.addr == CMD_ADDR && cyc.wdata == CODE_SETUP) else $error("erase set-up wrong");
  a_chip_confirm: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    cyc.start && step_reg == 3'h5 && op_reg == OP_CHIP_ERASE |->
    cyc.addr == CMD_ADDR && cyc.wdata == CODE_CHIP) else $error("chip confirm wrong");
  a_block_confirm: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    cyc.start && step_reg == 3'h5 && op_reg == OP_BLOCK_ERASE |->
    cyc.addr == addr_reg && cyc.wdata == CODE_BLOCK) else $error("block confirm wrong");
  a_prog_code: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    cyc.start && op_reg == OP_PROGRAM && step_reg == 3'h2 |->
    cyc.wdata == CODE_PROG ##1 (cyc.busy [*3])) else $error("program code wrong");
  a_suspend_legal: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    cyc.start && cyc.wr && op_reg == OP_SUSPEND |-> erase_reg && !susp_reg && cyc.wdata == CODE_SUSP)
    else $error("suspend outside block erase");
  a_wait_holds: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    $rose(state_reg == S_WAIT) |-> (state_reg == S_WAIT && !RSP_VALID) [*8])
    else $error("settle wait cut short");
  a_busy_no_ready: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    cyc.busy |-> !REQ_READY) else $error("request taken while cycle runs");
  a_fail_resets: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    state_reg == S_POLL_B && cyc.done && fail_seen_reg && cyc.rdata[FAIL_BIT] &&
    first_reg[TOGGLE_BIT] != cyc.rdata[TOGGLE_BIT] |=> state_reg == S_WRITE && op_reg == OP_RESET)
    else $error("failure not followed by reset");
  a_resume_code: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    cyc.start && op_reg == OP_RESUME |-> susp_reg && cyc.wdata == CODE_RESUME)
    else $error("resume wrong");
  c_program: cover property (@(posedge CLK_SYS) disable iff (!ARST_N)
    state_reg == S_POLL_B && op_reg == OP_PROGRAM ##1 RSP_VALID);
  c_chip_fail: cover property (@(posedge CLK_SYS) disable iff (!ARST_N)
    RSP_VALID && RSP_FAIL);
  c_suspend: cover property (@(posedge CLK_SYS) disable iff (!ARST_N)
    $rose(susp_reg) ##[1:300] RSP_VALID);
endmodule
`default_nettype wire

// >>> test/flash_dev_model.sv
// behavioural model of the byte-wide flash device on the far side
`default_nettype none
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter logic [18:0] U1A = 19'h00001,
  parameter logic [7:0] U1D = 8'h01,
  parameter logic [18:0] U2A = 19'h00002,
  parameter logic [7:0] U2D = 8'h02,
  parameter int WIN_NS = 3000
) (
  input wire logic [18:0] a,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [7:0] d,
  input wire logic inject_fail,
  output logic [7:0] q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [int];
  logic [18:0] blk [$];
  logic [7:0] last = 8'h00;
  logic tog = 1'b0;
  int step = 0;
  int mode = 0;  // 0 array, 1 program, 2 chip, 3 window, 4 block, 5 suspended
  int left = 0;
  time win_t = 0;
  wire wr_end = ce_n | we_n;
  wire rd_on = !ce_n && !oe_n;
  function automatic logic [7:0] rd(logic [18:0] x);
    rd = mem.exists(x) ? mem[x] : 8'hff;
  endfunction
  function automatic bit hit(logic [18:0] x);
    hit = 0;
    foreach (blk[i]) if (blk[i][18:16] == x[18:16]) hit = 1;
  endfunction
  always @(posedge wr_end) begin
    if (mode == 3 && d == CODE_BLOCK) begin blk.push_back(a); win_t = $time; end
    else if ((mode == 3 || mode == 4) && d == CODE_SUSP) mode = 5;
    else if (mode == 5 && d == CODE_RESUME) mode = 4;
    // return to array also clears a failed engine
    else if ((d == CODE_RESET && (mode >= 4 || inject_fail)) || mode == 3) begin mode = 0; step = 0; end
    else if (mode == 0) begin
      if (d == CODE_RESET) step = 0;
      else if (step == 0 || step == 3) step = (a == U1A && d == U1D) ? step + 1 : 0;
      else if (step == 1 || step == 4) step = (a == U2A && d == U2D) ? step + 1 : 0;
      else if (step == 2) step = a != CMD_ADDR ? 0 : d == CODE_PROG ? 6 : d == CODE_SETUP ? 3 : 0;
      else if (step == 6) begin mem[a] = rd(a) & d; mode = 1; left = 3; step = 0; end
      else if (step == 5) begin
        step = 0;
        left = 6;
        if (a == CMD_ADDR && d == CODE_CHIP) mode = 2;
        else if (d == CODE_BLOCK) begin mode = 3; blk = '{a}; win_t = $time; end
      end
    end
  end
  always @(posedge rd_on) begin
    // let the address pins settle before using them
    #1;
    if (mode == 3 && $time - win_t > WIN_NS) mode = 4;
    if (mode >= 1 && mode <= 4) begin
      tog = ~tog;
      last = {1'b0, tog, inject_fail, 1'b0, mode != 3, 3'h0};
      left -= (mode != 3 && !inject_fail);
      if (mode != 3 && left == 0) begin
        if (mode == 2) mem.delete();
        else foreach (mem[k]) if (hit(k[18:0])) mem[k] = 8'hff;
        mode = 0;
        blk.delete();
      end
    end else last = (mode == 5 && hit(a)) ? ~rd(a) : rd(a);
  end
  // released bus shows the inverse, never a stale byte
  assign q = rd_on ? last : ~last;
endmodule
`default_nettype wire

// >>> test/tb_flash_erase_host.sv
// self-checking bench for the flash command controller
`default_nettype none
module tb_flash_erase_host;
  import flash_host_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, v = 0, inj = 0, rdy, rv, rf, rr, ep, sus, ce_n, we_n, oe_n, oe;
  logic [3:0] op = 0;
  logic [18:0] ra = 0, fa;
  logic [7:0] wd = 0, rdat, dqo, dqi, fq;
  int num_errors = 0, samples_checked = 0;
  always #50 clk = ~clk;
  assign dqi = oe ? dqo : fq;
  flash_erase_host uut (.CLK_SYS(clk), .ARST_N(rst_n), .REQ_VALID(v), .REQ_READY(rdy), .REQ_OP(op),
    .REQ_ADDR(ra), .REQ_DATA(wd), .RSP_VALID(rv), .RSP_DATA(rdat), .RSP_FAIL(rf), .RSP_REFUSED(rr),
    .ERASE_PENDING(ep), .ERASE_SUSPENDED(sus), .FL_ADDR(fa), .FL_CE_N(ce_n), .FL_WE_N(we_n),
    .FL_OE_N(oe_n), .FL_DQ_OUT(dqo), .FL_DQ_OE(oe), .FL_DQ_IN(dqi));
  flash_dev_model dev (.a(fa), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .d(dqi), .inject_fail(inj), .q(fq));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin num_errors++; $display("Error %0t got %h want %h", $time, g, e); end
  endtask
  task automatic flag(input logic g, input logic e);
    chk({7'h00, g}, {7'h00, e});
  endtask
  // one request, held for one clock edge, then wait for its answer
  task automatic req(input logic [3:0] o, input logic [18:0] a, input logic [7:0] d);
    int n;
    op = o; ra = a; wd = d; v = 1'b1;
    @(posedge clk);
    #1 v = 1'b0;
    for (n = 0; n < 9000 && rv !== 1'b1; n++) @(posedge clk) #1;
    if (rv !== 1'b1) begin num_errors++; $display("Error %0t no answer", $time); end
    flag(rdy, 1'b1);
    // one idle edge keeps the next request off the edge that dropped this one
    @(posedge clk) #1;
  endtask
  task automatic t_prog;
    req(4'h1, 19'h00100, 8'h5a);
    req(4'h0, 19'h00100, 8'h00); chk(rdat, 8'h5a);
    req(4'h1, 19'h00100, 8'ha5);
    req(4'h0, 19'h00100, 8'h00); chk(rdat, 8'h00);
  endtask
  task automatic t_block;
    req(4'h1, 19'h10010, 8'h12);
    req(4'h3, 19'h10000, 8'h00); flag(ep, 1'b1);
    req(4'h4, 19'h20000, 8'h00); flag(rr, 1'b0);
    req(4'h8, 19'h10000, 8'h00); flag(ep, 1'b0);
    req(4'h0, 19'h10010, 8'h00); chk(rdat, 8'hff);
    req(4'h0, 19'h00100, 8'h00); chk(rdat, 8'h00);
  endtask
  task automatic t_susp;
    req(4'h1, 19'h30000, 8'h3c);
    req(4'h3, 19'h30000, 8'h00);
    req(4'h5, 19'h40000, 8'h00); flag(sus, 1'b1);
    req(4'h0, 19'h00100, 8'h00); chk(rdat, 8'h00);
    req(4'h8, 19'h30000, 8'h00); flag(rr, 1'b1);
    req(4'h6, 19'h00000, 8'h00); flag(sus, 1'b0);
    req(4'h8, 19'h30000, 8'h00); flag(ep, 1'b0);
    req(4'h0, 19'h30000, 8'h00); chk(rdat, 8'hff);
  endtask
  task automatic t_refuse;
    req(4'h5, 19'h00000, 8'h00); flag(rr, 1'b1);
    req(4'h9, 19'h00000, 8'h00); flag(rr, 1'b1);
  endtask
  task automatic t_chip;
    inj = 1'b1;
    req(4'h2, 19'h00000, 8'h00); flag(rf, 1'b1);
    inj = 1'b0;
    req(4'h2, 19'h00000, 8'h00); flag(rf, 1'b0);
    req(4'h0, 19'h00100, 8'h00); chk(rdat, 8'hff);
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #2ms num_errors++;
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    t_prog();
    t_block();
    t_susp();
    t_refuse();
    t_chip();
    wrap_up();
  end
endmodule
`default_nettype wire
